// ### design/dsrl_link.sv
`default_nettype none
// Behaviour
// - Dual-channel card: every own message is queued on both channels in the same cycle; a forwarded one leaves on one channel.
// - Single-channel card: outgoing messages leave on channel one only.
// - Received messages from other nodes are forwarded onward around the ring, except in a cycle that sends our own.
// - With no change, an integrity message is sent 1000 ms and one clock after the last own message, later if the channel is busy.
// - Changed status is sent at once unless the channel is busy.
// - In ring mode, own messages not returning raise the ring-break flag.
// - One offline flag for each of 16 node identifiers, set when its messages stop; our own is held clear.
// - Each own message carries our node identifier; identifiers in a ring are unique.
// - 128 kbps allowed only on fast fiber cards; all others run 64 kbps.
// - Both channels of a dual card share one configured rate.
// - Hop delivery about 0.2 cycle at the high rate, 0.4 at low.
// - G.703 and RS422 cards always run 64 kbps, ignoring the rate setting.
// - Crossover enabled: messages received on channel one leave on channel two.
// - Received messages are CRC-32 checked; failures counted apart from all received.
module dsrl_link #(
	parameter int unsigned INTEGRITY_CYCLES = dsrl_pkg::INTEGRITY_CYC,
	parameter int unsigned OFFLINE_CYCLES = dsrl_pkg::OFFLINE_CYC,
	parameter int unsigned CNT_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Configuration
	input wire logic [dsrl_pkg::ID_W-1:0] node_identifier,
	input wire logic dual_channel,
	input wire dsrl_pkg::dsrl_card_t card_type,
	input wire logic rate_high_req,
	input wire logic ring_mode,
	input wire logic channel_bridge_enable,
	// Local status to send
	input wire logic [dsrl_pkg::DATA_W-1:0] status_in,
	// Receive channels (same clock domain, from the deserialisers)
	input wire logic [1:0] rx_valid,
	input wire dsrl_pkg::dsrl_msg_t rx_msg [2],
	// Transmit channels
	output logic [1:0] tx_valid,
	input wire logic [1:0] tx_ready,
	output dsrl_pkg::dsrl_msg_t tx_msg [2],
	// Delivered peer status
	output logic peer_valid,
	output dsrl_pkg::dsrl_msg_t peer_msg,
	// Status
	output logic rate_high,
	output logic ring_break,
	output logic [dsrl_pkg::NODES-1:0] peer_offline,
	output logic [CNT_W-1:0] rx_total [2],
	output logic [CNT_W-1:0] rx_crc_fail [2]
);
	localparam int unsigned TMR_W = $clog2(INTEGRITY_CYCLES + 1);
	localparam int unsigned OFF_W = $clog2(OFFLINE_CYCLES + 1);

	function automatic logic [31:0] crc_of(input logic [dsrl_pkg::ID_W-1:0] src,
		input logic [dsrl_pkg::DATA_W-1:0] data);
		logic [31:0] c;
		logic [dsrl_pkg::ID_W+dsrl_pkg::DATA_W-1:0] w;
		c = dsrl_pkg::CRC_INIT;
		w = {src, data};
		for (int i = dsrl_pkg::ID_W + dsrl_pkg::DATA_W - 1; i >= 0; i--) begin
			c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? dsrl_pkg::CRC_POLY : 32'h00000000);
		end
		return c;
	endfunction : crc_of

	// Two-entry buffer per transmit channel; slot 0 is the head.
	typedef struct packed {
		dsrl_pkg::dsrl_slot_t [1:0] q;
	} dsrl_fifo_t;

	typedef struct packed {
		dsrl_fifo_t [1:0] txq;
		logic [TMR_W-1:0] integ;
		logic [dsrl_pkg::DATA_W-1:0] last_status;
		logic pend;
		logic own_sent;
		logic [TMR_W:0] ret_tmr;
		logic ring_break;
		logic [dsrl_pkg::NODES-1:0][OFF_W-1:0] off_tmr;
		logic [dsrl_pkg::NODES-1:0] offline;
		logic [1:0][CNT_W-1:0] total;
		logic [1:0][CNT_W-1:0] fail;
		logic peer_valid;
		dsrl_pkg::dsrl_msg_t peer_msg;
	} dsrl_state_t;

	dsrl_state_t s, next_s;
	logic [1:0] push;
	dsrl_pkg::dsrl_msg_t push_msg [2];
	logic [1:0] good;
	logic [1:0] own;
	logic [1:0] chan_on;
	dsrl_pkg::dsrl_msg_t own_msg;
	logic send_own;

	// Fast fiber cards alone may take the high rate; one rate serves both channels.
	// The chosen rate also fixes the hop delay, which the serialisers then set.
	assign rate_high = rate_high_req &&
		(card_type == dsrl_pkg::DSRL_CARD_FIBER_HI);
	assign chan_on = dual_channel ? 2'b11 : 2'b01;

	assign own_msg.src = node_identifier;
	assign own_msg.data = status_in;
	assign own_msg.crc = crc_of(node_identifier, status_in);

	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			assign good[c] = rx_valid[c] &&
				(rx_msg[c].crc == crc_of(rx_msg[c].src, rx_msg[c].data));
			assign own[c] = good[c] && (rx_msg[c].src == node_identifier);
			assign tx_valid[c] = s.txq[c].q[0].valid;
			assign tx_msg[c] = s.txq[c].q[0].msg;
			assign rx_total[c] = s.total[c];
			assign rx_crc_fail[c] = s.fail[c];
		end
	endgenerate

	always_comb begin
		next_s = s;
		push = 2'b00;
		push_msg[0] = own_msg;
		push_msg[1] = own_msg;
		send_own = 1'b0;
		next_s.peer_valid = 1'b0;

		// Own message: on a status change or when the integrity timer runs out.
		if (status_in != s.last_status) begin
			next_s.pend = 1'b1;
		end
		if (s.integ >= TMR_W'(INTEGRITY_CYCLES - 1)) begin
			next_s.pend = 1'b1;
		end
		// Only when every active channel has room, so the copies are queued in the same cycle.
		if ((s.pend || status_in != s.last_status) &&
			!((chan_on[0] && s.txq[0].q[1].valid) || (chan_on[1] && s.txq[1].q[1].valid))) begin
			send_own = 1'b1;
		end
		if (s.integ < TMR_W'(INTEGRITY_CYCLES - 1)) begin
			next_s.integ = s.integ + 1'b1;
		end
		if (send_own) begin
			push = chan_on;
			next_s.pend = 1'b0;
			next_s.integ = '0;
			next_s.last_status = status_in;
			next_s.own_sent = 1'b1;
		end else begin
			// Forwarding: a peer's message keeps going the way it was travelling.
			for (int c = 0; c < 2; c++) begin
				if (good[c] && !own[c]) begin
					if (c == 0 && channel_bridge_enable && dual_channel) begin
						push[1] = 1'b1;
						push_msg[1] = rx_msg[0];
					end else if (!push[1 - c] && chan_on[1 - c]) begin
						push[1 - c] = 1'b1;
						push_msg[1 - c] = rx_msg[c];
					end else if (!dual_channel && !push[0]) begin
						push[0] = 1'b1;
						push_msg[0] = rx_msg[c];
					end
				end
			end
		end

		// Buffers: pop on ready, then push into the first free slot.
		for (int c = 0; c < 2; c++) begin
			if (s.txq[c].q[0].valid && tx_ready[c]) begin
				next_s.txq[c].q[0] = s.txq[c].q[1];
				next_s.txq[c].q[1].valid = 1'b0;
			end
			if (push[c]) begin
				if (!next_s.txq[c].q[0].valid) begin
					next_s.txq[c].q[0] = '{valid: 1'b1, msg: push_msg[c]};
				end else if (!next_s.txq[c].q[1].valid) begin
					next_s.txq[c].q[1] = '{valid: 1'b1, msg: push_msg[c]};
				end
			end
			if (rx_valid[c]) begin
				next_s.total[c] = s.total[c] + 1'b1;
				if (!good[c]) begin
					next_s.fail[c] = s.fail[c] + 1'b1;
				end
			end
			if (good[c] && !own[c]) begin
				next_s.peer_valid = 1'b1;
				next_s.peer_msg = rx_msg[c];
			end
		end

		// Ring return supervision: one integrity period, with no added margin, to come back.
		if (!ring_mode) begin
			next_s.ring_break = 1'b0;
			next_s.ret_tmr = '0;
		end else if (own[0] || own[1]) begin
			next_s.ring_break = 1'b0;
			next_s.ret_tmr = '0;
		end else if (s.own_sent) begin
			if (s.ret_tmr >= (TMR_W + 1)'(INTEGRITY_CYCLES)) begin
				next_s.ring_break = 1'b1;
			end else begin
				next_s.ret_tmr = s.ret_tmr + 1'b1;
			end
		end

		// Peer offline timers.
		for (int n = 0; n < dsrl_pkg::NODES; n++) begin
			if ((good[0] && rx_msg[0].src == n[dsrl_pkg::ID_W-1:0]) ||
				(good[1] && rx_msg[1].src == n[dsrl_pkg::ID_W-1:0])) begin
				next_s.off_tmr[n] = '0;
				next_s.offline[n] = 1'b0;
			end else if (s.off_tmr[n] >= OFF_W'(OFFLINE_CYCLES - 1)) begin
				next_s.offline[n] = 1'b1;
			end else begin
				next_s.off_tmr[n] = s.off_tmr[n] + 1'b1;
			end
		end
		next_s.offline[node_identifier] = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ring_break = s.ring_break;
	assign peer_offline = s.offline;
	assign peer_valid = s.peer_valid;
	assign peer_msg = s.peer_msg;
endmodule : dsrl_link
`default_nettype wire

// ### design/dsrl_pkg.sv
`default_nettype none
package dsrl_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned INTEGRITY_MS = 1000;
	localparam int unsigned INTEGRITY_CYC = INTEGRITY_MS * (CLK_HZ / 1000);
	localparam int unsigned OFFLINE_MS = 1500;
	localparam int unsigned OFFLINE_CYC = OFFLINE_MS * (CLK_HZ / 1000);
	localparam int unsigned RATE_HI_KBPS = 128;
	localparam int unsigned RATE_LO_KBPS = 64;
	localparam int unsigned NODES = 16;
	localparam int unsigned ID_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CRC_W = 32;
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

	typedef enum logic [1:0] {
		DSRL_CARD_FIBER_HI = 2'b00,
		DSRL_CARD_FIBER_LO = 2'b01,
		DSRL_CARD_G703 = 2'b10,
		DSRL_CARD_RS422 = 2'b11
	} dsrl_card_t;

	typedef struct packed {
		logic [ID_W-1:0] src;
		logic [DATA_W-1:0] data;
		logic [CRC_W-1:0] crc;
	} dsrl_msg_t;

	typedef struct packed {
		logic valid;
		dsrl_msg_t msg;
	} dsrl_slot_t;
endpackage : dsrl_pkg
`default_nettype wire

// ### dv/dsrl_link_monitor.sv
`default_nettype none
module dsrl_link_monitor #(
	parameter int unsigned INTEGRITY_CYCLES = 50,
	parameter int unsigned CNT_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Configuration and receive side
	input wire logic [3:0] node_identifier,
	input wire logic dual_channel,
	input wire dsrl_pkg::dsrl_card_t card_type,
	input wire logic rate_high_req,
	input wire logic [1:0] rx_valid,
	// Transmit and status side
	input wire logic [1:0] tx_valid,
	input wire logic [1:0] tx_ready,
	input wire dsrl_pkg::dsrl_msg_t tx_msg [2],
	input wire logic peer_valid,
	input wire dsrl_pkg::dsrl_msg_t peer_msg,
	input wire logic rate_high,
	input wire logic [15:0] peer_offline,
	input wire logic [CNT_W-1:0] rx_total [2],
	input wire logic [CNT_W-1:0] rx_crc_fail [2]
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// A stalled head keeps tx_valid up, so only a silent channel counts as idle.
	int unsigned idle;
	always_ff @(posedge clk) begin
		if (!nrst || tx_valid[0]) idle <= 0;
		else idle <= idle + 1;
	end
	AST_RATE: assert property (
		rate_high == (rate_high_req && card_type == dsrl_pkg::DSRL_CARD_FIBER_HI)
	) else $error("link rate wrong");
	AST_SINGLE: assert property (!dual_channel |-> !tx_valid[1]
	) else $error("second channel used");
	AST_HOLD: assert property (
		tx_valid[1] && !tx_ready[1] |=> tx_valid[1] && $stable(tx_msg[1])
	) else $error("head lost under stall");
	AST_PEER_SRC: assert property (
		peer_valid |-> peer_msg.src != node_identifier
	) else $error("own message delivered");
	AST_PEER_CAUSE: assert property (
		peer_valid |-> $past(rx_valid[0] | rx_valid[1])
	) else $error("delivery without reception");
	AST_OWN_ON: assert property (peer_offline[node_identifier] == 1'b0
	) else $error("own node offline");
	AST_TOTAL: assert property (
		rx_valid[0] |=> rx_total[0] == CNT_W'($past(rx_total[0]) + 1)
	) else $error("total count wrong");
	AST_FAIL: assert property (
		!rx_valid[0] |=> $stable(rx_crc_fail[0])
	) else $error("fail count moved");
	AST_INTEG: assert property (idle <= INTEGRITY_CYCLES + 3
	) else $error("integrity gap too long");
endmodule : dsrl_link_monitor
`default_nettype wire

// ### dv/dsrl_link_tb.sv
`default_nettype none
module dsrl_link_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] ME = 4'h3;
	logic clk = 1'b0, nrst = 1'b0, dual_channel = 1'b1, ring_mode = 1'b1;
	logic channel_bridge_enable = 1'b0, rate_high_req = 1'b0, bad = 1'b0, stall = 1'b0;
	logic [3:0] node_identifier = ME, src = 4'h0;
	logic [31:0] status_in = 32'h0, data = 32'h0;
	logic [1:0] send = 2'h0, rx_valid, tx_valid, tx_ready;
	dsrl_pkg::dsrl_card_t card_type = dsrl_pkg::DSRL_CARD_FIBER_HI;
	dsrl_pkg::dsrl_msg_t rx_msg [2], tx_msg [2], peer_msg;
	logic peer_valid, rate_high, ring_break;
	logic [15:0] peer_offline, rx_total [2], rx_crc_fail [2], lfsr = 16'h4859;
	logic [67:0] expq [$];
	logic [31:0] got [2];
	int n_errors = 0, total_checks = 0, cyc = 0;
	dsrl_link #(.INTEGRITY_CYCLES(50), .OFFLINE_CYCLES(80)) DUT (.*);
	dsrl_peer_model PEER (.*);
	initial begin
		forever #2.5 clk = ~clk;
	end
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	task automatic check(input logic [67:0] seen, input logic [67:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		lfsr <= lfsr_next(lfsr);
		stall <= lfsr[0] & lfsr[3];
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			stop_test();
		end
	end
	always @(negedge clk) begin
		if (peer_valid === 1'b1)
			check({peer_msg.src, peer_msg.data, 32'h0}, expq.size() ? expq.pop_front() : 'x);
	end
	task automatic send_msg(input int c, input logic [3:0] s, input logic b);
		@(posedge clk);
		send <= 2'(1 << c);
		src <= s;
		data <= {lfsr, ~lfsr};
		bad <= b;
		if (!b && s != ME) expq.push_back({s, lfsr, ~lfsr, 32'h0});
		@(posedge clk);
		send <= 2'h0;
	endtask : send_msg
	task automatic wait_pop(input int c, input logic [3:0] s, output logic [31:0] d);
		d = 'x;
		for (int i = 0; i < 200; i++) begin
			@(negedge clk);
			if (tx_valid[c] && tx_ready[c] && tx_msg[c].src === s) begin
				d = tx_msg[c].data;
				break;
			end
		end
	endtask : wait_pop
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			card_type <= dsrl_pkg::dsrl_card_t'(i[1:0]);
			rate_high_req <= i[2];
			@(negedge clk);
			check(68'(rate_high), 68'(i[2] && i[1:0] == 0));
		end
		$display("test rate done");
		@(posedge clk);
		status_in <= {lfsr, ~lfsr};
		fork
			wait_pop(0, ME, got[0]);
			wait_pop(1, ME, got[1]);
		join
		check(68'(got[0]), 68'(status_in));
		check(68'(got[1]), 68'(status_in));
		$display("test own send done");
		@(posedge clk);
		channel_bridge_enable <= 1'b1;
		send_msg(0, 4'h5, 1'b0);
		wait_pop(1, 4'h5, got[1]);
		check(68'(got[1]), 68'(data));
		send_msg(0, 4'h6, 1'b1);
		repeat (3) @(negedge clk);
		check(68'({rx_total[0], rx_crc_fail[0]}), 68'(32'h0002_0001));
		$display("test receive done");
		repeat (90) @(negedge clk);
		check(68'({ring_break, peer_offline[5]}), 68'(2'b11));
		send_msg(0, ME, 1'b0);
		send_msg(1, 4'h5, 1'b0);
		repeat (3) @(negedge clk);
		check(68'({ring_break, peer_offline[5]}), 68'(2'b00));
		$display("test supervision done");
		// A card change is only legal under reset, so the buffers start empty.
		@(posedge clk);
		nrst <= 1'b0;
		dual_channel <= 1'b0;
		ring_mode <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		check(68'({tx_valid, ring_break, peer_offline, rx_total[0]}), 68'(0));
		wait_pop(0, ME, got[0]);
		check(68'(got[0]), 68'(status_in));
		check(68'(tx_valid[1]), 68'(0));
		send_msg(1, 4'h8, 1'b0);
		wait_pop(0, 4'h8, got[0]);
		check(68'(got[0]), 68'(data));
		repeat (60) @(negedge clk);
		check(68'(ring_break), 68'(0));
		check(68'(expq.size()), 68'(0));
		$display("test single channel done");
		stop_test();
	end
endmodule : dsrl_link_tb
bind dsrl_link dsrl_link_monitor #(.INTEGRITY_CYCLES(INTEGRITY_CYCLES), .CNT_W(CNT_W)) MON (.*);
`default_nettype wire

// ### dv/dsrl_peer_model.sv
`default_nettype none
module dsrl_peer_model (
	// Clock and bench requests
	input wire logic clk,
	input wire logic [1:0] send,
	input wire logic [3:0] src,
	input wire logic [31:0] data,
	input wire logic bad,
	input wire logic stall,
	// Link side
	output logic [1:0] rx_valid,
	output dsrl_pkg::dsrl_msg_t rx_msg [2],
	output logic [1:0] tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	function automatic logic [31:0] crc32(input logic [35:0] d);
		logic [31:0] c;
		c = dsrl_pkg::CRC_INIT;
		for (int i = 35; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ (c[31] ^ d[i] ? dsrl_pkg::CRC_POLY : 32'h0);
		return c;
	endfunction : crc32
	initial begin
		rx_valid = 2'h0;
		tx_ready = 2'h0;
		rx_msg[0] = '0;
		rx_msg[1] = '0;
	end
	// The peer shares the device clock, so it always runs at the same link rate.
	always @(posedge clk) begin
		tx_ready <= {2{~stall}};
		for (int c = 0; c < 2; c++) begin
			rx_valid[c] <= send[c];
			// A bad frame flips one check bit; an idle line shows the inverse word.
			rx_msg[c] <= send[c] ? {src, data, crc32({src, data}) ^ {31'h0, bad}} : ~rx_msg[c];
		end
	end
endmodule : dsrl_peer_model
`default_nettype wire
